//--- rtl/sfpc_top.sv
// serial flash protect control: link front end and command core
`timescale 1ns/1ps
module sfpc_top #(
  parameter int STAT_CYC  = sfpc_pkg::STATUS_WR_CYCLES,
  parameter int PAGE_CYC  = sfpc_pkg::PAGE_WR_CYCLES,
  parameter int SECT_CYC  = sfpc_pkg::SECTOR_WIPE_CYCLES,
  parameter int BLOCK_CYC = sfpc_pkg::BLOCK_WIPE_CYCLES,
  parameter int CHIP_CYC  = sfpc_pkg::CHIP_WIPE_CYCLES,
  parameter int PUW_CYC   = sfpc_pkg::POWER_UP_WRITE_DELAY_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        sck,
  input  wire logic        cs_n,
  input  wire logic [3:0]  io_in,
  output logic      [3:0]  io_out,
  output logic      [3:0]  io_oe,
  output logic      [1:0]  read_lanes,
  output logic             dev_active,
  output logic             arr_prog,
  output logic             arr_erase,
  output logic      [1:0]  arr_wipe_size,
  output logic             arr_otp,
  output logic      [19:0] arr_addr,
  output logic      [7:0]  arr_data
);
  // link state cleared by deselect
  typedef struct packed {
    logic       fresh;
    logic       opc_pos;
    logic [7:0] sh;
    logic       st_rd;
    logic [1:0] lanes;
  } sfpc_frame_type;
  // link state that survives deselect
  typedef struct packed {
    logic [2:0] cnt;
    logic [7:0] hold;
    logic       tog;
    logic       quad;
  } sfpc_link_type;
  // falling-edge output state
  typedef struct packed {
    logic [7:0] sbuf;
    logic [2:0] ocnt;
    logic [3:0] out;
    logic [3:0] oe;
  } sfpc_out_type;
  typedef struct packed {
    logic                  tog_seen;
    logic                  armed;
    logic                  in_frame;
    logic                  frame_ok;
    logic [9:0]            nbytes;
    logic [7:0]            opc;
    logic [23:0]           addr;
    logic [7:0]            wsr;
    logic [255:0][7:0]     pbuf;
    logic [8:0]            pcnt;
    logic                  write_latch_flag;
    logic [2:0]            level;
    logic                  pin_dis;
    logic                  lock;
    logic                  seal;
    logic                  otp;
    logic                  pdown;
    logic                  busy;
    sfpc_pkg::sfpc_op_type op;
    logic                  otp_op;
    logic [23:0]           timer;
    logic [8:0]            emit;
    logic [23:0]           puw;
    logic                  hwp;
    logic                  active;
    logic [7:0]            status_pub;
    logic                  arr_prog;
    logic                  arr_erase;
    logic [1:0]            wsize;
    logic [19:0]           arr_addr;
    logic [7:0]            arr_data;
  } sfpc_core_type;

  sfpc_frame_type lf;
  sfpc_frame_type next_lf;
  sfpc_link_type  lk;
  sfpc_link_type  next_lk;
  sfpc_out_type   lo;
  sfpc_out_type   next_lo;
  sfpc_core_type  c;
  sfpc_core_type  next_c;
  logic [1:0]     pin_s;
  logic [4:0]     link_s;
  logic           cs_hi;
  logic           wp_n_s;
  logic           tog_s;
  logic [2:0]     cnt_s;
  logic           quad_s;

  // ---------------- link, rising edge ----------------
  always_comb begin
    logic [2:0] step;
    logic [2:0] base;
    logic [2:0] new_cnt;
    logic [7:0] sh_base;
    logic [7:0] new_sh;
    step    = lk.quad ? sfpc_pkg::QUAD_STEP : sfpc_pkg::SINGLE_STEP;
    base    = lf.fresh ? 3'h0 : lk.cnt;
    sh_base = lf.fresh ? 8'h00 : lf.sh;
    new_cnt = base + step;
    // sample on the rising edge, msb first; quad takes a nibble
    new_sh  = lk.quad ? {sh_base[3:0], io_in}
                      : {sh_base[6:0], io_in[0]};
    next_lf       = lf;
    next_lk       = lk;
    next_lf.fresh = 1'b0;
    next_lf.sh    = new_sh;
    next_lk.cnt   = new_cnt;
    if (new_cnt == 3'h0) begin
      next_lk.hold    = new_sh;
      next_lk.tog     = ~lk.tog;
      next_lf.opc_pos = 1'b0;
      if (lf.opc_pos) begin
        next_lf.st_rd = (new_sh == sfpc_pkg::STATUS_READ_CMD);
        if (lk.quad) begin
          next_lf.lanes = sfpc_pkg::LANES_QUAD;
        end else if (new_sh == sfpc_pkg::DUAL_OUT_READ_CMD ||
                     new_sh == sfpc_pkg::DUAL_IO_READ_CMD) begin
          next_lf.lanes = sfpc_pkg::LANES_DUAL;
        end else if (new_sh == sfpc_pkg::QUAD_IO_READ_CMD) begin
          next_lf.lanes = sfpc_pkg::LANES_QUAD;
        end
        if (new_sh == sfpc_pkg::QUAD_MODE_ENTER_CMD) begin
          next_lk.quad = 1'b1;
        end else if (lk.quad &&
                     new_sh == sfpc_pkg::QUAD_MODE_EXIT_CMD) begin
          next_lk.quad = 1'b0;
        end
      end
    end
  end

  // the frame's own select ends it, so no edge after the last is needed
  always_ff @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      lf         <= '0;
      lf.fresh   <= 1'b1;
      lf.opc_pos <= 1'b1;
    end else begin
      lf <= next_lf;
    end
  end

  always_ff @(posedge sck or posedge rst) begin
    if (rst) begin
      lk <= '0;
    end else begin
      lk <= next_lk;
    end
  end

  // ---------------- link, falling edge ----------------
  // status_pub only moves while deselected, so it is steady here
  always_comb begin
    logic [7:0] d;
    next_lo = lo;
    d       = (lo.ocnt == 3'h0) ? c.status_pub : lo.sbuf;
    if (lf.st_rd) begin
      if (lk.quad) begin
        next_lo.out  = d[7:4];
        next_lo.oe   = 4'hf;
        next_lo.sbuf = {d[3:0], 4'h0};
        next_lo.ocnt = lo.ocnt + sfpc_pkg::QUAD_STEP;
      end else begin
        next_lo.out  = {2'h0, d[7], 1'b0};
        next_lo.oe   = 4'h2;
        next_lo.sbuf = {d[6:0], 1'b0};
        next_lo.ocnt = lo.ocnt + sfpc_pkg::SINGLE_STEP;
      end
    end
  end

  // deselect floats every lane at once
  always_ff @(negedge sck or posedge cs_n) begin
    if (cs_n) begin
      lo <= '0;
    end else begin
      lo <= next_lo;
    end
  end

  // ---------------- crossings into ref_clk ----------------
  sfpc_sync #(.WIDTH(2)) u_pin_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({cs_n, io_in[2]}),
    .sync_out (pin_s)
  );

  sfpc_sync #(.WIDTH(5)) u_link_sync (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({lk.tog, lk.cnt, lk.quad}),
    .sync_out (link_s)
  );

  assign cs_hi  = pin_s[1];
  assign wp_n_s = pin_s[0];
  assign tog_s  = link_s[4];
  assign cnt_s  = link_s[3:1];
  assign quad_s = link_s[0];

  function automatic logic prot_hit(input logic otp, input logic seal,
                                    input logic [2:0] lvl,
                                    input logic [19:0] a);
    if (otp) begin
      return seal;
    end
    return (lvl != sfpc_pkg::LEVEL_NONE) &&
           (a <= sfpc_pkg::PROTECT_LIMIT[lvl]);
  endfunction : prot_hit

  // ---------------- command core ----------------
  always_comb begin
    logic       bits_ok;
    logic       mod_ok;
    logic [7:0] idx;
    logic [19:0] wbase;
    next_c           = c;
    next_c.arr_prog  = 1'b0;
    next_c.arr_erase = 1'b0;
    // write position follows the data byte count, so bytes past 256 wrap
    idx     = c.addr[7:0] + c.nbytes[7:0] - 8'h04;
    // an erase is judged by the base of the whole region it clears
    wbase   = (c.opc == sfpc_pkg::SECTOR_WIPE_CMD)
            ? {c.addr[19:12], 12'h000} : {c.addr[19:16], 16'h0000};
    bits_ok = (cnt_s == 3'h0);
    mod_ok  = bits_ok && c.write_latch_flag && (c.puw == 24'h0);
    if (c.puw != 24'h0) begin
      next_c.puw = c.puw - 24'h1;
    end
    // protect pin is a data lane in quad mode
    next_c.hwp = c.lock && !wp_n_s && !c.pin_dis && !quad_s;
    if (cs_hi) begin
      next_c.armed = 1'b1;
    end
    if (c.busy) begin
      if (c.op == sfpc_pkg::OP_PROGRAM && c.emit < c.pcnt) begin
        next_c.arr_prog = 1'b1;
        next_c.arr_addr = {c.addr[19:8], c.addr[7:0] + c.emit[7:0]};
        next_c.arr_data = c.pbuf[c.addr[7:0] + c.emit[7:0]];
        next_c.emit     = c.emit + 9'h1;
      end
      if (c.timer == 24'h0) begin
        next_c.busy = 1'b0;
        next_c.write_latch_flag  = 1'b0;
        next_c.op   = sfpc_pkg::OP_IDLE;
        if (c.op == sfpc_pkg::OP_STATUS) begin
          if (c.otp_op) begin
            next_c.seal = 1'b1;
          end else begin
            next_c.pin_dis = c.wsr[sfpc_pkg::PIN_DISABLE_BIT];
            if (!c.hwp) begin
              next_c.lock  = c.wsr[sfpc_pkg::LOCK_BIT];
              next_c.level = c.wsr[sfpc_pkg::LEVEL_MSB:sfpc_pkg::LEVEL_LSB];
            end
          end
        end
      end else begin
        next_c.timer = c.timer - 24'h1;
      end
    end
    if (!cs_hi && !c.in_frame) begin
      next_c.in_frame = 1'b1;
      next_c.frame_ok = c.armed;
      next_c.nbytes   = 10'h000;
      if (!c.busy) begin
        next_c.pcnt = 9'h000;
      end
    end else if (tog_s != c.tog_seen) begin
      next_c.tog_seen = tog_s;
      if (c.in_frame) begin
        if (c.nbytes != sfpc_pkg::BYTE_COUNT_MAX) begin
          next_c.nbytes = c.nbytes + 10'h001;
        end
        if (c.nbytes == 10'h000) begin
          next_c.opc = lk.hold;
        end else if (!c.busy) begin
          if (c.nbytes < sfpc_pkg::WIPE_ADDR_BYTES) begin
            next_c.addr = {c.addr[15:0], lk.hold};
            if (c.nbytes == 10'h001) begin
              next_c.wsr = lk.hold;
            end
          end else begin
            // later bytes wrap inside the page, keeping the last 256
            next_c.pbuf[idx] = lk.hold;
            if (c.pcnt != sfpc_pkg::PAGE_BYTES) begin
              next_c.pcnt = c.pcnt + 9'h001;
            end
          end
        end
      end
    end else if (cs_hi && c.in_frame) begin
      next_c.in_frame = 1'b0;
      if (!c.frame_ok || c.busy) begin
        next_c.in_frame = 1'b0;
      end else if (c.pdown) begin
        if (c.opc == sfpc_pkg::WAKE_AND_ID_CMD) begin
          next_c.pdown = 1'b0;
        end
      end else begin
        unique case (c.opc)
          sfpc_pkg::LATCH_SET_CMD: begin
            if (bits_ok) next_c.write_latch_flag = 1'b1;
          end
          sfpc_pkg::LATCH_CLEAR_CMD: begin
            if (bits_ok) begin
              next_c.write_latch_flag = 1'b0;
              next_c.otp = 1'b0;
            end
          end
          sfpc_pkg::ONE_TIME_ENTER_CMD: begin
            if (bits_ok) next_c.otp = 1'b1;
          end
          sfpc_pkg::POWER_DOWN_CMD: begin
            if (bits_ok) next_c.pdown = 1'b1;
          end
          sfpc_pkg::STATUS_WRITE_CMD: begin
            if (mod_ok && c.nbytes >= sfpc_pkg::STATUS_WR_MIN_BYTES) begin
              next_c.busy   = 1'b1;
              next_c.op     = sfpc_pkg::OP_STATUS;
              next_c.timer  = 24'(STAT_CYC);
              next_c.otp_op = c.otp;
            end
          end
          sfpc_pkg::PAGE_WRITE_CMD: begin
            // host keeps latch, opcode, address, data order
            if (mod_ok && c.nbytes >= sfpc_pkg::PAGE_WR_MIN_BYTES &&
                !prot_hit(c.otp, c.seal, c.level, c.addr[19:0])) begin
              next_c.busy   = 1'b1;
              next_c.op     = sfpc_pkg::OP_PROGRAM;
              next_c.timer  = 24'(PAGE_CYC);
              next_c.emit   = 9'h000;
              next_c.otp_op = c.otp;
            end
          end
          sfpc_pkg::SECTOR_WIPE_CMD, sfpc_pkg::BLOCK_WIPE_CMD: begin
            if (mod_ok && c.nbytes == sfpc_pkg::WIPE_ADDR_BYTES &&
                !prot_hit(c.otp, c.seal, c.level, wbase)) begin
              next_c.busy      = 1'b1;
              next_c.op        = sfpc_pkg::OP_WIPE;
              next_c.otp_op    = c.otp;
              next_c.arr_erase = 1'b1;
              next_c.arr_addr  = wbase;
              if (c.opc == sfpc_pkg::SECTOR_WIPE_CMD) begin
                next_c.wsize    = sfpc_pkg::WIPE_SECTOR;
                next_c.timer    = 24'(SECT_CYC);
              end else begin
                next_c.wsize    = sfpc_pkg::WIPE_BLOCK;
                next_c.timer    = 24'(BLOCK_CYC);
              end
            end
          end
          sfpc_pkg::CHIP_WIPE_CMD_A, sfpc_pkg::CHIP_WIPE_CMD_B: begin
            if (mod_ok && (c.otp ? !c.seal
                                 : c.level == sfpc_pkg::LEVEL_NONE)) begin
              next_c.busy      = 1'b1;
              next_c.op        = sfpc_pkg::OP_WIPE;
              next_c.otp_op    = c.otp;
              next_c.arr_erase = 1'b1;
              next_c.wsize     = sfpc_pkg::WIPE_CHIP;
              next_c.timer     = 24'(CHIP_CYC);
              next_c.arr_addr  = 20'h00000;
            end
          end
          default: begin
            next_c.in_frame = 1'b0;
          end
        endcase
      end
    end
    next_c.active = next_c.in_frame || next_c.busy;
    if (cs_hi) begin
      next_c.status_pub = {c.otp ? c.seal : c.lock, c.pin_dis, 1'b0,
                           c.level, c.write_latch_flag, c.busy};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      c         <= '0;
      c.puw     <= 24'(PUW_CYC);
      c.level   <= sfpc_pkg::PROTECT_LEVEL_RESET;
      c.pin_dis <= sfpc_pkg::PIN_DISABLE_RESET;
      c.lock    <= sfpc_pkg::LOCK_RESET;
      c.seal    <= sfpc_pkg::SEAL_RESET;
    end else begin
      c <= next_c;
    end
  end

  assign io_out        = lo.out;
  assign io_oe         = lo.oe;
  assign read_lanes    = lf.lanes;
  assign dev_active    = c.active;
  assign arr_prog      = c.arr_prog;
  assign arr_erase     = c.arr_erase;
  assign arr_wipe_size = c.wsize;
  assign arr_otp       = c.otp_op;
  assign arr_addr      = c.arr_addr;
  assign arr_data      = c.arr_data;

  // ---------------- checks ----------------
  a_latch_needed: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(c.busy) |-> $past(c.write_latch_flag)) else $error("cycle without latch");
  a_latch_cleared: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(c.busy) |-> !c.write_latch_flag) else $error("latch kept after cycle");
  a_powerup_block: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(c.busy) |-> $past(c.puw) == 24'h0) else $error("early write");
  a_pdown_ignore: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(c.busy) |-> !$past(c.pdown)) else $error("cmd in power down");
  a_whole_bytes: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(c.busy) |-> $past(cnt_s) == 3'h0) else $error("partial byte");
  a_hw_freeze: assert property (@(posedge ref_clk) disable iff (rst)
    (c.hwp && !c.otp_op && $past(c.hwp)) |=> $stable(c.lock) && $stable(c.level))
    else $error("locked field changed");
  a_seal_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    c.seal |=> c.seal) else $error("seal cleared");
  a_stay_active: assert property (@(posedge ref_clk) disable iff (rst)
    c.busy |-> c.active) else $error("standby during cycle");
  a_wipe_unprot: assert property (@(posedge ref_clk) disable iff (rst)
    (c.arr_erase && c.wsize != sfpc_pkg::WIPE_CHIP) |->
      !prot_hit(c.otp_op, c.seal, c.level, c.arr_addr))
    else $error("protected wipe");
  a_cycle_steady: assert property (@(posedge ref_clk) disable iff (rst)
    (c.busy && $past(c.busy)) |-> $stable(c.op) && $stable(c.otp_op))
    else $error("cycle disturbed");
  c_program: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(c.busy) && c.op == sfpc_pkg::OP_PROGRAM);
  c_wipe: cover property (@(posedge ref_clk) disable iff (rst)
    c.arr_erase);
  c_status_wr: cover property (@(posedge ref_clk) disable iff (rst)
    $fell(c.busy) ##1 c.lock);
  c_pdown: cover property (@(posedge ref_clk) disable iff (rst)
    $rose(c.pdown));
endmodule : sfpc_top

//--- include/sfpc_pkg.sv
// shared constants and types for the serial flash protect control block
package sfpc_pkg;
  // one-byte opcodes, shifted most significant bit first
  localparam logic [7:0] LATCH_SET_CMD       = 8'h06;
  localparam logic [7:0] LATCH_CLEAR_CMD     = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD     = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD    = 8'h01;
  localparam logic [7:0] PAGE_WRITE_CMD      = 8'h02;
  localparam logic [7:0] SECTOR_WIPE_CMD     = 8'h20;
  localparam logic [7:0] BLOCK_WIPE_CMD      = 8'hd8;
  localparam logic [7:0] CHIP_WIPE_CMD_A     = 8'hc7;
  localparam logic [7:0] CHIP_WIPE_CMD_B     = 8'h60;
  localparam logic [7:0] POWER_DOWN_CMD      = 8'hb9;
  localparam logic [7:0] WAKE_AND_ID_CMD     = 8'hab;
  localparam logic [7:0] QUAD_MODE_ENTER_CMD = 8'h38;
  localparam logic [7:0] QUAD_MODE_EXIT_CMD  = 8'hff;
  localparam logic [7:0] ONE_TIME_ENTER_CMD  = 8'h3a;
  localparam logic [7:0] DUAL_OUT_READ_CMD   = 8'h3b;
  localparam logic [7:0] DUAL_IO_READ_CMD    = 8'hbb;
  localparam logic [7:0] QUAD_IO_READ_CMD    = 8'heb;
  // status byte layout
  localparam int CYCLE_ACTIVE_BIT = 0;
  localparam int WRITE_LATCH_BIT  = 1;
  localparam int LEVEL_LSB        = 2;
  localparam int LEVEL_MSB        = 4;
  localparam int PIN_DISABLE_BIT  = 6;
  localparam int LOCK_BIT         = 7;
  // nonvolatile reset values
  localparam logic [2:0] PROTECT_LEVEL_RESET = 3'h0;
  localparam logic       PIN_DISABLE_RESET   = 1'b0;
  localparam logic       LOCK_RESET          = 1'b0;
  localparam logic       SEAL_RESET          = 1'b0;
  // last read-only address per protect level, region starts at zero
  localparam logic [7:0][19:0] PROTECT_LIMIT = {
    20'hfffff, 20'hbffff, 20'hdffff, 20'heffff,
    20'hf7fff, 20'hfbfff, 20'hfdfff, 20'h00000};
  localparam logic [2:0] LEVEL_NONE = 3'h0;
  // lane usage and wipe sizes
  localparam logic [1:0] LANES_SINGLE = 2'h0;
  localparam logic [1:0] LANES_DUAL   = 2'h1;
  localparam logic [1:0] LANES_QUAD   = 2'h2;
  localparam logic [1:0] WIPE_SECTOR  = 2'h0;
  localparam logic [1:0] WIPE_BLOCK   = 2'h1;
  localparam logic [1:0] WIPE_CHIP    = 2'h2;
  localparam logic [2:0] SINGLE_STEP  = 3'h1;
  localparam logic [2:0] QUAD_STEP    = 3'h4;
  // frame length checks in bytes
  localparam logic [9:0] STATUS_WR_MIN_BYTES = 10'h002;
  localparam logic [9:0] PAGE_WR_MIN_BYTES   = 10'h005;
  localparam logic [9:0] WIPE_ADDR_BYTES     = 10'h004;
  localparam logic [9:0] BYTE_COUNT_MAX      = 10'h3ff;
  localparam logic [8:0] PAGE_BYTES          = 9'h100;
  // cycle lengths in ref_clk cycles
  localparam int STATUS_WR_CYCLES   = 512;
  localparam int PAGE_WR_CYCLES     = 1024;
  localparam int SECTOR_WIPE_CYCLES = 8192;
  localparam int BLOCK_WIPE_CYCLES  = 32768;
  localparam int CHIP_WIPE_CYCLES   = 262144;
  localparam int POWER_UP_WRITE_DELAY_CYCLES = 2048;
  typedef enum logic [1:0] {
    OP_IDLE    = 2'b00,
    OP_STATUS  = 2'b01,
    OP_PROGRAM = 2'b10,
    OP_WIPE    = 2'b11
  } sfpc_op_type;
endpackage : sfpc_pkg

//--- rtl/sfpc_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module sfpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] held;
  } sfpc_sync_type;

  sfpc_sync_type r;
  sfpc_sync_type next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = async_in;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // a change counts only once stages two and three agree
    if (r.s2 == r.s3) begin
      next_r.held = r.s2;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.held;
endmodule : sfpc_sync

//--- dv/sfpc_host_model.sv
// spi host model for the flash link, mode 0
`timescale 1ns/1ps
module sfpc_host_model (
  output logic            sck,
  output logic            cs_n,
  output logic [3:0]      io_in,
  input  wire logic [3:0] io_out
);
  initial begin
    sck   = 1'b0; // idles low outside frames
    cs_n  = 1'b1;
    io_in = 4'hc; // protect pin inactive
  end
  task automatic bit_cyc(input logic v, inout logic [7:0] rd);
    io_in[0] = v; // change after falling edge
    #32 sck = 1'b1;
    rd = {rd[6:0], io_out[1]};
    #32 sck = 1'b0;
  endtask : bit_cyc
  // whole bytes msb first; extra clocks break the boundary
  task automatic xfer(input logic [7:0] q[$], input int extra,
                      output logic [7:0] rd);
    rd = 8'h00;
    #3 cs_n = 1'b0;
    foreach (q[i]) begin
      for (int b = 7; b >= 0; b--) bit_cyc(q[i][b], rd);
    end
    for (int b = 0; b < extra; b++) bit_cyc(1'b1, rd);
    #32 cs_n = 1'b1;
    io_in[0] = ~io_in[0]; // released line must not keep its value
    #240;
  endtask : xfer
endmodule : sfpc_host_model

//--- dv/tb_top.sv
// self-checking bench for the serial flash protect control block
`timescale 1ns/1ps
module tb_top;
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        sck, cs_n, dev_active, arr_prog, arr_erase, arr_otp;
  logic [3:0]  io_in, io_out, io_oe;
  logic [1:0]  read_lanes, arr_wipe_size;
  logic [19:0] arr_addr, pa;
  logic [7:0]  arr_data, rd;
  logic [22:0] er_seen;
  logic [1:0]  lanes_seen;
  logic [3:0]  oe_seen;
  logic [27:0] ex_q[$];
  int          failures    = 0;
  int          check_count = 0;
  int          n_prog      = 0;
  sfpc_top #(.STAT_CYC(300), .PAGE_CYC(300), .SECT_CYC(300),
    .BLOCK_CYC(300), .PUW_CYC(20)) u_sfpc_top (
    .ref_clk, .rst, .sck, .cs_n, .io_in, .io_out, .io_oe, .read_lanes,
    .dev_active, .arr_prog, .arr_erase, .arr_wipe_size, .arr_otp,
    .arr_addr, .arr_data);
  sfpc_host_model u_sfpc_host_model (.sck, .cs_n, .io_in, .io_out);
  always #4 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // sampled mid-cycle so the flops have settled
  always @(negedge ref_clk) begin
    if (arr_prog === 1'b1) begin
      n_prog++;
      chk({arr_addr, arr_data}, ex_q.pop_front());
    end
    if (arr_erase === 1'b1) er_seen = {arr_otp, arr_wipe_size, arr_addr};
  end
  // lanes move on rising sck, enables on falling: look at the other edge
  always @(negedge sck) if (cs_n === 1'b0) lanes_seen = read_lanes;
  always @(posedge sck) if (cs_n === 1'b0) oe_seen = io_oe;
  task automatic wrap_up;
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic cmd(input logic [7:0] c);
    u_sfpc_host_model.xfer({c}, 0, rd);
  endtask : cmd
  task automatic rd_stat;
    u_sfpc_host_model.xfer({8'h05, 8'h00}, 0, rd);
  endtask : rd_stat
  task automatic wait_idle;
    for (int i = 0; i < 40; i++) begin
      rd_stat();
      if (rd[0] === 1'b0) return;
    end
    failures++;
    wrap_up();
  endtask : wait_idle
  // ok marks a frame whose bytes must reach the array
  task automatic prog(input logic [19:0] a, input int n, input int extra,
                      input bit ok);
    logic [7:0] q[$];
    logic [7:0] d;
    q = {8'h02, 8'(a[19:16]), a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      q.push_back(d);
      if (ok) ex_q.push_back({a[19:8], 8'(a[7:0] + i), d});
    end
    u_sfpc_host_model.xfer(q, extra, rd);
  endtask : prog
  initial begin
    void'($urandom(22));
    pa = 20'($urandom);
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    repeat (40) @(negedge ref_clk);
    rd_stat();
    chk(rd, 8'h00);
    chk(oe_seen, 4'h2);
    chk(io_oe, 4'h0);
    u_sfpc_host_model.xfer({8'h3b, 8'h00}, 0, rd);
    chk(lanes_seen, sfpc_pkg::LANES_DUAL);
    u_sfpc_host_model.xfer({8'heb, 8'h00}, 0, rd);
    chk(lanes_seen, sfpc_pkg::LANES_QUAD);
    prog(pa, 2, 0, 0);
    chk(n_prog, 0);
    cmd(8'h06);
    prog(pa, 2, 3, 0);
    rd_stat();
    chk(rd, 8'h02);
    prog(pa, 256, 0, 1);
    rd_stat();
    chk(rd, 8'h03);
    chk(dev_active, 1'b1);
    wait_idle();
    chk(rd, 8'h00);
    chk(dev_active, 1'b0);
    chk(n_prog, 256);
    cmd(8'h06);
    u_sfpc_host_model.xfer({8'h20, 8'(pa[19:16]), pa[15:8], pa[7:0]},
                           0, rd);
    wait_idle();
    chk(er_seen, {1'b0, sfpc_pkg::WIPE_SECTOR, pa[19:12], 12'h000});
    cmd(8'hb9);
    cmd(8'h06);
    u_sfpc_host_model.xfer({8'hab, 8'h00, 8'h00, 8'h00}, 0, rd);
    rd_stat();
    chk(rd, 8'h00);
    cmd(8'h06);
    u_sfpc_host_model.xfer({8'h01, 8'h04}, 0, rd);
    wait_idle();
    chk(rd, 8'h04);
    cmd(8'h06);
    // block base lies in the protected part; chip wipe needs level none
    u_sfpc_host_model.xfer({8'hd8, 8'h0f, 8'he0, 8'h00}, 0, rd);
    u_sfpc_host_model.xfer({8'hc7}, 0, rd);
    chk(er_seen, {1'b0, sfpc_pkg::WIPE_SECTOR, pa[19:12], 12'h000});
    prog(20'h0fd00, 1, 0, 0);
    rd_stat();
    chk(rd, 8'h06);
    prog(20'hfe000, 1, 0, 1);
    wait_idle();
    chk(n_prog, 257);
    wrap_up();
  end
endmodule : tb_top
